// ### inc/fcpc_pkg.sv
// Summary of operation
// - Pulling the fabric manual reset pin low resets the download logic.
// - Every manual reset assertion sends the phase to manual reset from any phase.
// - Mode select pins are captured when each clear cycle ends and pick the settings.
// - Load clock is an input in slave modes, driven out in master mode once the manual reset and clear phases are over.
// - Serial configuration moves one bit at a time over the serial data pin.
// - Configuration errors are reported on the open-drain error flag pin.
// - Open-drain start/status pin starts a download and reports configuration status.
// - Active-high load indicator is high for the whole download.
// - Active-low load indicator is low for the whole download.
// - Cascade enable output enables the next device downstream in the chain.
// - Verify request held low at download start enables the check function.
// - User I/O tri-state input low puts every user I/O in high impedance.
package fcpc_pkg;

	// ==========================================
	// Timing
	localparam int REF_PERIOD_NS = 50;
	localparam int CLEAR_TIME_NS = 2000;
	localparam int CLEAR_CYCLES = (CLEAR_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	localparam int LOAD_CLOCK_HALF_CYCLES = 4;

	// ==========================================
	// Sizes and modes
	localparam int WORD_BITS = 32;
	localparam int CONFIG_WORDS = 16;
	localparam logic [2:0] MODE_MASTER = 3'h0;
	localparam logic [2:0] MODE_SLAVE_CS = 3'h1;
	localparam logic [2:0] MODE_RESET = 3'h0;

	// ==========================================
	// Lifephases
	typedef enum logic [2:0] {
		PH_MRESET,
		PH_CLEAR,
		PH_IDLE,
		PH_LOAD,
		PH_RUN,
		PH_FAIL
	} fcpc_phase_t;

endpackage : fcpc_pkg

// ### tb/fabric_config_pin_control_test.sv
`timescale 1ns/1ns

module fabric_config_pin_control_test;
	// ==========================================
	// Signals
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic fabric_reset_n = 1'b1;
	logic [2:0] mode = 3'h1;
	logic serial_m = 1'b0;
	logic verify_request_n = 1'b1;
	logic user_io_tristate_n = 1'b1;
	logic src_clk, src_data, src_cs_n, src_start, src_err;
	logic load_clock_out, load_clock_oe, error_flag_out, error_flag_oe;
	logic load_start_status_out, load_start_status_oe;
	logic load_active_high, load_active_low, cascade_enable_out, user_io_hiz, cfg_word_valid;
	logic [2:0] load_mode;
	logic [31:0] cfg_word;
	logic [31:0] got[$];
	logic [63:0] stream;
	int err_count = 0;
	int checked = 0;
	// Pins resolved from every party; the open-drain error and start pins have pull-ups
	wire load_clock_w = load_clock_oe ? load_clock_out : src_clk;
	wire serial_w = (mode == 3'h0) ? serial_m : src_data;
	wire error_w = ~((error_flag_oe & ~error_flag_out) | src_err);
	wire start_w = ~((load_start_status_oe & ~load_start_status_out) | src_start);

	always #25 ref_clk = ~ref_clk;

	fcpc_src src (.clk_out(src_clk), .data(src_data), .cs_n(src_cs_n), .start_pull(src_start), .err_pull(src_err));

	fcpc_top #(.N_WORDS(2)) uut (
		.ref_clk(ref_clk), .reset(reset), .fabric_reset_n(fabric_reset_n),
		.load_mode_sel0(mode[0]), .load_mode_sel1(mode[1]), .load_mode_sel2(mode[2]),
		.load_clock_in(load_clock_w), .load_clock_out(load_clock_out), .load_clock_oe(load_clock_oe),
		.serial_load_data(serial_w), .slave_chip_select_n(src_cs_n),
		.error_flag_in(error_w), .error_flag_out(error_flag_out), .error_flag_oe(error_flag_oe),
		.load_start_status_in(start_w), .load_start_status_out(load_start_status_out),
		.load_start_status_oe(load_start_status_oe), .load_active_high(load_active_high),
		.load_active_low(load_active_low), .cascade_enable_out(cascade_enable_out),
		.verify_request_n(verify_request_n), .user_io_tristate_n(user_io_tristate_n),
		.user_io_hiz(user_io_hiz), .load_mode(load_mode), .cfg_word(cfg_word), .cfg_word_valid(cfg_word_valid)
	);

	always @(posedge ref_clk) begin
		if (cfg_word_valid === 1'b1) begin
			got.push_back(cfg_word);
		end
	end

	// ==========================================
	// Helpers
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// Sample one step after the edge so its updates have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc

	task automatic mreset(input logic [2:0] m);
		@(posedge ref_clk) mode <= m;
		@(posedge ref_clk) fabric_reset_n <= 1'b0;
		cyc(6);
		chk("start_oe", 32'(load_start_status_oe), 32'h1);
		chk("cascade", 32'(cascade_enable_out), 32'h0);
		chk("error_oe", 32'(error_flag_oe), 32'h0);
		@(posedge ref_clk) fabric_reset_n <= 1'b1;
		cyc(48);
		chk("load_mode", 32'(load_mode), 32'(m));
		chk("start_oe", 32'(load_start_status_oe), 32'h0);
		chk("clock_oe", 32'(load_clock_oe), 32'(m == 3'h0));
		got.delete();
	endtask : mreset

	task automatic start(input logic ver_n);
		@(posedge ref_clk) verify_request_n <= ver_n;
		src.pulse_start();
		cyc(4);
		chk("active_high", 32'(load_active_high), 32'h1);
		chk("active_low", 32'(load_active_low), 32'h0);
		chk("start_oe", 32'(load_start_status_oe), 32'h1);
	endtask : start

	task automatic done_ok(input logic [31:0] w0, input logic [31:0] w1);
		cyc(20);
		chk("word0", got[0], w0);
		chk("word1", got[1], w1);
		chk("cascade", 32'(cascade_enable_out), 32'h1);
		chk("error_oe", 32'(error_flag_oe), 32'h0);
		chk("active_high", 32'(load_active_high), 32'h0);
		chk("active_low", 32'(load_active_low), 32'h1);
		chk("start_oe", 32'(load_start_status_oe), 32'h0);
		chk("error_out", 32'(error_flag_out), 32'h0);
		chk("start_out", 32'(load_start_status_out), 32'h0);
	endtask : done_ok

	// ==========================================
	// Scenarios
	task automatic t_slave_cs();
		src.send_word(32'h0, 1'b0);
		start(1'b1);
		src.send_word(32'hdeadbeef, 1'b0);
		src.send_word(32'h80000001, 1'b1);
		src.send_word(32'h5a3c0ff0, 1'b1);
		done_ok(32'h80000001, 32'h5a3c0ff0);
		@(posedge ref_clk) user_io_tristate_n <= 1'b0;
		cyc(4);
		chk("user_io_hiz", 32'(user_io_hiz), 32'h1);
		@(posedge ref_clk) user_io_tristate_n <= 1'b1;
		cyc(4);
		chk("user_io_hiz", 32'(user_io_hiz), 32'h0);
		$display("test slave_cs done");
	endtask : t_slave_cs

	// Chip select is ignored here; last word breaks the checksum
	task automatic t_slave_fail();
		mreset(3'h2);
		src.send_word(32'h0, 1'b0);
		start(1'b0);
		src.lead_in(2);
		src.send_word(32'h12345678, 1'b0);
		src.send_word(32'h12345679, 1'b0);
		cyc(10);
		chk("word0", got[0], 32'h12345678);
		chk("error_oe", 32'(error_flag_oe), 32'h1);
		chk("cascade", 32'(cascade_enable_out), 32'h0);
		$display("test slave_fail done");
	endtask : t_slave_fail

	task automatic t_ext_error();
		mreset(3'h5);
		src.send_word(32'h0, 1'b0);
		start(1'b1);
		src.pulse_err();
		cyc(6);
		chk("error_oe", 32'(error_flag_oe), 32'h1);
		chk("cascade", 32'(cascade_enable_out), 32'h0);
		$display("test ext_error done");
	endtask : t_ext_error

	// Next bit goes out after each load clock rise, so it is steady through the low half
	task automatic t_master();
		mreset(3'h0);
		stream = {32'hc3a50f71, 32'hc3a50f71};
		@(posedge ref_clk) serial_m <= stream[63];
		fork
			start(1'b0);
			for (int i = 62; i >= 0; i--) begin
				@(posedge load_clock_out);
				@(posedge ref_clk) serial_m <= stream[i];
			end
		join
		done_ok(32'hc3a50f71, 32'hc3a50f71);
		chk("clock_oe", 32'(load_clock_oe), 32'h1);
		$display("test master done");
	endtask : t_master

	// ==========================================
	// Run control
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		cyc(9);
		chk("start_oe", 32'(load_start_status_oe), 32'h1);
		chk("active_low", 32'(load_active_low), 32'h1);
		chk("user_io_hiz", 32'(user_io_hiz), 32'h1);
		@(posedge ref_clk) reset <= 1'b0;
		cyc(48);
		chk("load_mode", 32'(load_mode), 32'h1);
		t_slave_cs();
		t_slave_fail();
		t_ext_error();
		t_master();
		report_and_stop();
	end

	initial begin
		#3000000;
		err_count++;
		$display("watchdog expired");
		report_and_stop();
	end
endmodule : fabric_config_pin_control_test

// ### tb/fcpc_src.sv
`timescale 1ns/1ns

// ==========================================
// Configuration source at the far side of the load pins
module fcpc_src (
	// Link
	output logic clk_out,
	output logic data,
	output logic cs_n,
	// Open-drain pulls, high = pull low
	output logic start_pull,
	output logic err_pull
);
	initial begin
		clk_out = 1'b1;
		data = 1'b0;
		cs_n = 1'b1;
		start_pull = 1'b0;
		err_pull = 1'b0;
	end

	// Gap after each word keeps word time above what the crossing needs
	task automatic send_word(input logic [31:0] w, input logic sel);
		for (int i = 31; i >= 0; i--) begin
			clk_out = 1'b0;
			data = w[i];
			cs_n = ~sel;
			#3 clk_out = 1'b1;
			#3;
		end
		data = ~data;
		cs_n = 1'b1;
		#150;
	endtask : send_word

	// Enable reaches the link side only after two load clock edges, so those carry no data
	task automatic lead_in(input int n);
		repeat (n) begin
			clk_out = 1'b0;
			cs_n = 1'b1;
			#3 clk_out = 1'b1;
			#3;
		end
	endtask : lead_in

	// Non-blocking, since these may be called in the time step of a ref clock edge
	task automatic pulse_start();
		start_pull <= 1'b1;
		#200 start_pull <= 1'b0;
	endtask : pulse_start

	task automatic pulse_err();
		err_pull <= 1'b1;
		#200 err_pull <= 1'b0;
	endtask : pulse_err
endmodule : fcpc_src

// ### verilog/fcpc_sync.sv
`timescale 1ns/1ns

// ==========================================
// Two-stage synchroniser
// First stage feeds only the second stage
module fcpc_sync #(
	parameter int W = 1
) (
	// Clock
	input wire logic clk,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta;

	always_ff @(posedge clk) begin
		meta <= d;
		q <= meta;
	end

endmodule : fcpc_sync

// ### verilog/fcpc_top.sv
`timescale 1ns/1ns

module fcpc_top #(
	parameter int WORD_W = fcpc_pkg::WORD_BITS,
	parameter int N_WORDS = fcpc_pkg::CONFIG_WORDS,
	parameter int LOAD_CLOCK_HALF = fcpc_pkg::LOAD_CLOCK_HALF_CYCLES
) (
	// System
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic fabric_reset_n,
	// Mode select
	input wire logic load_mode_sel0,
	input wire logic load_mode_sel1,
	input wire logic load_mode_sel2,
	// Load clock
	input wire logic load_clock_in,
	output logic load_clock_out,
	output logic load_clock_oe,
	// Serial data and chip select
	input wire logic serial_load_data,
	input wire logic slave_chip_select_n,
	// Error flag, open drain
	input wire logic error_flag_in,
	output logic error_flag_out,
	output logic error_flag_oe,
	// Start and status, open drain
	input wire logic load_start_status_in,
	output logic load_start_status_out,
	output logic load_start_status_oe,
	// Indicators
	output logic load_active_high,
	output logic load_active_low,
	output logic cascade_enable_out,
	// Check request and user I/O
	input wire logic verify_request_n,
	input wire logic user_io_tristate_n,
	output logic user_io_hiz,
	// Fabric side
	output logic [2:0] load_mode,
	output logic [WORD_W-1:0] cfg_word,
	output logic cfg_word_valid
);

	// ==========================================
	// Pin synchronisers
	logic [8:0] raw_pins;
	logic [8:0] sync_pins;
	logic mreset_n_s;
	logic start_s;
	logic err_s;
	logic verify_n_s;
	logic tristate_n_s;
	logic [2:0] mode_s;
	logic data_s;

	assign raw_pins = {fabric_reset_n, load_start_status_in, error_flag_in, verify_request_n,
		user_io_tristate_n, load_mode_sel2, load_mode_sel1, load_mode_sel0, serial_load_data};

	fcpc_sync #(.W(9)) u_pin_sync (
		.clk(ref_clk),
		.d(raw_pins),
		.q(sync_pins)
	);

	assign mreset_n_s = sync_pins[8];
	assign start_s = sync_pins[7];
	assign err_s = sync_pins[6];
	assign verify_n_s = sync_pins[5];
	assign tristate_n_s = sync_pins[4];
	assign mode_s = sync_pins[3:1];
	assign data_s = sync_pins[0];

	// ==========================================
	// Control state
	fcpc_pkg::fcpc_phase_t phase;
	logic [6:0] clr_cnt;
	logic clr_done;
	logic start_prev;
	logic start_fall;
	logic check_en;
	logic [15:0] word_cnt;
	logic [WORD_W-1:0] sum;
	logic is_master;
	logic word_evt;
	logic [WORD_W-1:0] word_in;
	logic last_word;
	logic sum_bad;

	assign clr_done = phase == fcpc_pkg::PH_CLEAR && clr_cnt == 7'(fcpc_pkg::CLEAR_CYCLES - 1);
	// Edge, not level: our own release would otherwise look like a start request
	assign start_fall = start_prev && !start_s;
	assign is_master = load_mode == fcpc_pkg::MODE_MASTER;
	assign last_word = word_evt && word_cnt == 16'(N_WORDS - 1);
	assign sum_bad = check_en && word_in != sum;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			phase <= fcpc_pkg::PH_MRESET;
		end else if (!mreset_n_s) begin
			phase <= fcpc_pkg::PH_MRESET;
		end else begin
			case (phase)
				fcpc_pkg::PH_MRESET: begin
					phase <= fcpc_pkg::PH_CLEAR;
				end
				fcpc_pkg::PH_CLEAR: begin
					if (clr_done) begin
						phase <= fcpc_pkg::PH_IDLE;
					end
				end
				fcpc_pkg::PH_IDLE: begin
					if (start_fall) begin
						phase <= fcpc_pkg::PH_LOAD;
					end
				end
				fcpc_pkg::PH_LOAD: begin
					if (!err_s || (last_word && sum_bad)) begin
						phase <= fcpc_pkg::PH_FAIL;
					end else if (last_word) begin
						phase <= fcpc_pkg::PH_RUN;
					end
				end
				fcpc_pkg::PH_RUN: begin
					phase <= fcpc_pkg::PH_RUN;
				end
				fcpc_pkg::PH_FAIL: begin
					phase <= fcpc_pkg::PH_FAIL;
				end
				default: begin
					phase <= fcpc_pkg::PH_MRESET;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset || phase != fcpc_pkg::PH_CLEAR) begin
			clr_cnt <= 7'h00;
		end else begin
			clr_cnt <= clr_cnt + 7'h01;
		end
	end

	// Mode pins are only looked at when a clear cycle ends
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			load_mode <= fcpc_pkg::MODE_RESET;
		end else if (clr_done && mreset_n_s) begin
			load_mode <= mode_s;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			start_prev <= 1'b0;
		end else begin
			start_prev <= start_s;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			check_en <= 1'b0;
		end else if (phase == fcpc_pkg::PH_IDLE && start_fall) begin
			check_en <= !verify_n_s;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset || phase != fcpc_pkg::PH_LOAD) begin
			word_cnt <= 16'h0000;
			sum <= '0;
		end else if (word_evt) begin
			word_cnt <= word_cnt + 16'h0001;
			sum <= sum ^ word_in;
		end
	end

	// ==========================================
	// Master mode: load clock made here
	logic [7:0] div_cnt;
	logic load_clock;
	logic m_bit_evt;
	logic [WORD_W-1:0] m_shreg;
	logic [7:0] m_bitcnt;
	logic m_word_evt;
	logic m_load;

	assign m_load = phase == fcpc_pkg::PH_LOAD && is_master;
	// Sample just before the rising edge; LOAD_CLOCK_HALF of 3 or more covers the synchroniser delay
	assign m_bit_evt = m_load && !load_clock && div_cnt == 8'(LOAD_CLOCK_HALF - 1);
	assign m_word_evt = m_bit_evt && m_bitcnt == 8'(WORD_W - 1);

	always_ff @(posedge ref_clk) begin
		if (reset || !m_load) begin
			div_cnt <= 8'h00;
			load_clock <= 1'b0;
		end else if (div_cnt == 8'(LOAD_CLOCK_HALF - 1)) begin
			div_cnt <= 8'h00;
			load_clock <= !load_clock;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset || !m_load) begin
			m_bitcnt <= 8'h00;
			m_shreg <= '0;
		end else if (m_bit_evt) begin
			m_shreg <= {m_shreg[WORD_W-2:0], data_s};
			m_bitcnt <= m_word_evt ? 8'h00 : m_bitcnt + 8'h01;
		end
	end

	// ==========================================
	// Slave mode: link domain on the load clock
	logic [1:0] link_ctl;
	logic [1:0] link_ctl_s;
	logic s_en;
	logic s_cs_mode;
	logic s_sel;
	logic [WORD_W-1:0] s_shreg;
	logic [WORD_W-1:0] s_hold;
	logic [7:0] s_bitcnt;
	logic s_tgl;

	assign link_ctl = {phase == fcpc_pkg::PH_LOAD && !is_master, load_mode == fcpc_pkg::MODE_SLAVE_CS};

	fcpc_sync #(.W(2)) u_link_sync (
		.clk(load_clock_in),
		.d(link_ctl),
		.q(link_ctl_s)
	);

	assign s_en = link_ctl_s[1];
	assign s_cs_mode = link_ctl_s[0];
	assign s_sel = !s_cs_mode || !slave_chip_select_n;

	// Word held steady for a full word time while the ref side catches the toggle
	always_ff @(posedge load_clock_in) begin
		if (!s_en) begin
			s_bitcnt <= 8'h00;
			s_tgl <= 1'b0;
		end else if (s_sel) begin
			s_shreg <= {s_shreg[WORD_W-2:0], serial_load_data};
			if (s_bitcnt == 8'(WORD_W - 1)) begin
				s_bitcnt <= 8'h00;
				s_hold <= {s_shreg[WORD_W-2:0], serial_load_data};
				s_tgl <= !s_tgl;
			end else begin
				s_bitcnt <= s_bitcnt + 8'h01;
			end
		end
	end

	// ==========================================
	// Word crossing back to the ref domain
	logic tgl_s;
	logic tgl_seen;
	logic s_word_evt;

	fcpc_sync #(.W(1)) u_tgl_sync (
		.clk(ref_clk),
		.d(s_tgl),
		.q(tgl_s)
	);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tgl_seen <= 1'b0;
		end else begin
			tgl_seen <= tgl_s;
		end
	end

	assign s_word_evt = phase == fcpc_pkg::PH_LOAD && !is_master && tgl_s != tgl_seen;
	assign word_evt = is_master ? m_word_evt : s_word_evt;
	assign word_in = is_master ? {m_shreg[WORD_W-2:0], data_s} : s_hold;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cfg_word <= '0;
			cfg_word_valid <= 1'b0;
		end else begin
			cfg_word_valid <= word_evt;
			if (word_evt) begin
				cfg_word <= word_in;
			end
		end
	end

	// ==========================================
	// Pin outputs
	logic od_low;

	always_ff @(posedge ref_clk) begin
		od_low <= 1'b0;
	end

	assign error_flag_out = od_low;
	assign load_start_status_out = od_low;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			load_clock_out <= 1'b0;
			load_clock_oe <= 1'b0;
		end else begin
			load_clock_out <= load_clock;
			load_clock_oe <= is_master && phase != fcpc_pkg::PH_MRESET && phase != fcpc_pkg::PH_CLEAR;
		end
	end

	// Status pin is released in idle and held low through the download until the fabric runs, so a host sees completion as release
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			load_start_status_oe <= 1'b1;
			error_flag_oe <= 1'b0;
		end else begin
			load_start_status_oe <= phase != fcpc_pkg::PH_IDLE && phase != fcpc_pkg::PH_RUN;
			error_flag_oe <= phase == fcpc_pkg::PH_FAIL;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			load_active_high <= 1'b0;
			load_active_low <= 1'b1;
			cascade_enable_out <= 1'b0;
			user_io_hiz <= 1'b1;
		end else begin
			load_active_high <= phase == fcpc_pkg::PH_LOAD;
			load_active_low <= phase != fcpc_pkg::PH_LOAD;
			cascade_enable_out <= phase == fcpc_pkg::PH_RUN;
			user_io_hiz <= !tristate_n_s;
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence s_start_req;
		phase == fcpc_pkg::PH_IDLE && start_fall && mreset_n_s;
	endsequence

	sequence s_load_shown;
		phase == fcpc_pkg::PH_LOAD ##1 load_active_high && !load_active_low && load_start_status_oe;
	endsequence

	property p_mreset;
		!mreset_n_s |=> phase == fcpc_pkg::PH_MRESET ##1 phase == fcpc_pkg::PH_MRESET || phase == fcpc_pkg::PH_CLEAR;
	endproperty
	a_mreset: assert property (p_mreset) else $error("manual reset did not reach reset phase");

	property p_mode_capture;
		clr_done && mreset_n_s |=> load_mode == $past(mode_s) && phase == fcpc_pkg::PH_IDLE;
	endproperty
	a_mode_capture: assert property (p_mode_capture) else $error("mode not captured at clear end");

	property p_start;
		s_start_req |=> s_load_shown;
	endproperty
	a_start: assert property (p_start) else $error("start request did not begin download");

	property p_indicators;
		load_active_high |-> !load_active_low && $past(phase) == fcpc_pkg::PH_LOAD;
	endproperty
	a_indicators: assert property (p_indicators) else $error("load indicators disagree");

	property p_check;
		s_start_req and !verify_n_s |=> check_en;
	endproperty
	a_check: assert property (p_check) else $error("verify request not latched");

	property p_error;
		phase == fcpc_pkg::PH_FAIL && mreset_n_s |=> error_flag_oe [*2];
	endproperty
	a_error: assert property (p_error) else $error("error flag not pulled low");

	property p_cascade;
		$rose(cascade_enable_out) |-> $past(phase, 1) == fcpc_pkg::PH_RUN && !load_active_high;
	endproperty
	a_cascade: assert property (p_cascade) else $error("cascade enable without run phase");

	property p_hiz;
		!tristate_n_s ##1 !tristate_n_s |-> user_io_hiz;
	endproperty
	a_hiz: assert property (p_hiz) else $error("user I/O not tri-stated");

	property p_open_drain;
		!error_flag_out && !load_start_status_out;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open-drain pin driven high");

	property p_load_clock_dir;
		load_clock_oe |-> is_master;
	endproperty
	a_load_clock_dir: assert property (p_load_clock_dir) else $error("load clock driven in slave mode");

endmodule : fcpc_top
